//--- rtl/multi_io_fast_read_wrap.sv
// Read-side command sequencer for multi-line fast reads with burst wrap
//
// How it works
// R1 - Quad output read needs quad enable
// R2 - Quad output: opcode, 24-bit address, eight dummies
// R3 - Host releases IO lines before data
// R4 - Dual IO read: address and data two lines
// R5 - Mode byte follows address in IO reads
// R6 - Select bits 10 skip opcode next frame
// R7 - Other select bits restore opcode decoding
// R8 - Host exits dual continuous mode with ones
// R9 - Host exits quad continuous mode with ones
// R10 - Quad IO read: four lines, four dummies
// R11 - Quad IO read needs quad enable
// R12 - Wrap loops within aligned page section
// R13 - Set wrap: opcode, 24 dummies, wrap byte
// R14 - Wrap disable bit and length select
// R15 - Wrap setting persists for later reads
// R16 - Wrap disabled after reset
// R17 - Four-wire dummy count 2/4/6/8, default 2
// R18 - Four-wire mode byte counts as dummy
// R19 - Four-wire quad IO keeps continuous mode
// R20 - Four-wire quad IO read never wraps
// R21 - Wrap length kept, reloadable by parameters
// R22 - Address increments after each output byte
// R23 - Most significant bits on highest line
`default_nettype none

module multi_io_fast_read_wrap
  import fast_read_pkg::*;
(
  input  wire logic                 i_mclk,
  input  wire logic                 i_sys_rst,
  input  wire logic                 i_cs_n,
  input  wire logic                 i_sclk,
  input  wire logic [3:0]           i_io_in,
  input  wire logic                 i_quad_enable_bit,
  input  wire logic                 i_four_wire_command_mode,
  input  wire read_param_t          i_read_param,
  input  wire logic                 i_read_param_load,
  input  wire logic [7:0]           i_mem_data,
  output logic [3:0]                o_io_out,
  output logic [3:0]                o_io_oe_n,
  output logic [ADDR_BITS-1:0]      o_mem_addr,
  output logic [2:0]                o_wrap_setting_bits,
  output logic [1:0]                o_dummy_sel,
  output logic                      o_continuous_read_active,
  output logic                      o_data_phase
);

  seq_regs_t            q;
  seq_regs_t            n;
  logic                 rise;
  logic                 fall;
  logic [ADDR_BITS-1:0] shifted;
  logic [ADDR_BITS-1:0] addr_inc;
  logic [ADDR_BITS-1:0] addr_next;
  logic [ADDR_BITS-1:0] wrap_mask;
  logic [7:0]           wrap_mask8;
  logic                 wrap_on;
  logic [4:0]           qpi_dummy;
  logic [2:0]           data_lanes;
  logic [7:0]           load_byte;

  // ==========================================================================
  // Line enable patterns, active low per line
  localparam logic [3:0] OE_RELEASED = 4'hf;
  localparam logic [3:0] OE_DUAL     = 4'hc;
  localparam logic [3:0] OE_QUAD     = 4'h0;
  localparam int         BYTE_BITS   = 8;

  // ==========================================================================
  // Helpers
  function automatic logic [ADDR_BITS-1:0] shift_in(input logic [ADDR_BITS-1:0] v,
                                                    input logic [3:0]           io,
                                                    input logic [2:0]           w);
    case (w)
      LANES_QUAD: return {v[ADDR_BITS-5:0], io};
      LANES_DUAL: return {v[ADDR_BITS-3:0], io[1:0]};
      default:    return {v[ADDR_BITS-2:0], io[0]};
    endcase
  endfunction : shift_in

  function automatic logic [2:0] lanes_of(input logic [7:0] c);
    if (c == OPC_DUAL_IO_READ) begin
      return LANES_DUAL;
    end
    return LANES_QUAD;
  endfunction : lanes_of

  function automatic logic [4:0] addr_clks(input logic [2:0] w);
    case (w)
      LANES_QUAD: return ADDR_CLKS_QUAD;
      LANES_DUAL: return ADDR_CLKS_DUAL;
      default:    return ADDR_CLKS_SINGLE;
    endcase
  endfunction : addr_clks

  // ==========================================================================
  // Next-state logic
  always_comb begin
    n          = q;
    rise       = q.sclk_s[1] & ~q.sclk_d;
    fall       = ~q.sclk_s[1] & q.sclk_d;
    shifted    = shift_in(q.sh, q.io_s[1], q.lanes);
    addr_inc   = q.addr + {{(ADDR_BITS-1){1'b0}}, 1'b1};
    wrap_mask8 = 8'((WRAP_MIN_BYTES << q.wrap[2:1]) - 8'h01);
    wrap_mask  = {{(ADDR_BITS-8){1'b0}}, wrap_mask8};
    wrap_on    = (q.cmd == OPC_QUAD_IO_READ) && !q.wrap[WRAP_DIS_IDX]            // R12 R15
                 && !i_four_wire_command_mode;                                  // R20
    addr_next  = wrap_on ? ((q.addr & ~wrap_mask) | (addr_inc & wrap_mask))    // R12
                         : addr_inc;                                            // R22
    qpi_dummy  = 5'((DUMMY_STEP_QPI * ({3'h0, q.dummy_sel} + 5'h01)) - MODE_CLKS_QUAD); // R17 R18
    data_lanes = (q.cmd == OPC_DUAL_IO_READ) ? LANES_DUAL : LANES_QUAD;
    load_byte  = i_mem_data;

    n.cs_n_s = {q.cs_n_s[0], i_cs_n};
    n.sclk_s = {q.sclk_s[0], i_sclk};
    n.io_s   = {q.io_s[0], i_io_in};
    n.sclk_d = q.sclk_s[1];

    if (i_read_param_load) begin
      n.dummy_sel = i_read_param.dummy_sel;                                     // R17
      n.wrap[2:1] = i_read_param.wrap_len;                                      // R21
    end

    if (q.cs_n_s[1]) begin
      // Deselected: release lines and arm the next frame
      n.io_oe_n = OE_RELEASED;
      n.io_out  = 4'h0;
      n.sh      = '0;
      n.dclk    = 3'h0;
      if (q.cont) begin
        n.st    = ST_ADDR;                                                      // R6 R19
        n.cmd   = q.cont_cmd;
        n.lanes = lanes_of(q.cont_cmd);
        n.cnt   = addr_clks(lanes_of(q.cont_cmd));
      end else begin
        n.st    = ST_OPCODE;                                                    // R7
        n.cmd   = 8'h00;
        n.lanes = i_four_wire_command_mode ? LANES_QUAD : LANES_SINGLE;
        n.cnt   = i_four_wire_command_mode ? OPC_CLKS_QUAD : OPC_CLKS_SERIAL;
      end
    end else if (rise) begin
      n.sh  = shifted;
      n.cnt = q.cnt - 5'h01;
      case (q.st)
        ST_OPCODE: begin
          if (q.cnt == 5'h01) begin
            n.cmd = shifted[7:0];
            n.sh  = '0;
            if (shifted[7:0] == OPC_QUAD_OUT_READ && i_quad_enable_bit         // R1
                && !i_four_wire_command_mode) begin
              n.st    = ST_ADDR;                                                // R2
              n.lanes = LANES_SINGLE;
              n.cnt   = ADDR_CLKS_SINGLE;
            end else if (shifted[7:0] == OPC_DUAL_IO_READ && !i_four_wire_command_mode) begin
              n.st    = ST_ADDR;                                                // R4
              n.lanes = LANES_DUAL;
              n.cnt   = ADDR_CLKS_DUAL;
            end else if (shifted[7:0] == OPC_QUAD_IO_READ && i_quad_enable_bit) begin // R11
              n.st    = ST_ADDR;                                                // R10
              n.lanes = LANES_QUAD;
              n.cnt   = ADDR_CLKS_QUAD;
            end else if (shifted[7:0] == OPC_SET_WRAP && !i_four_wire_command_mode) begin
              n.st    = ST_SET_WRAP;                                            // R13
              n.lanes = LANES_QUAD;
              n.cnt   = SET_WRAP_CLKS;
            end else begin
              n.st = ST_IGNORE;
            end
          end
        end
        ST_ADDR: begin
          if (q.cnt == 5'h01) begin
            n.addr = shifted;                                                   // R23
            n.sh   = '0;
            if (q.cmd == OPC_QUAD_OUT_READ) begin
              n.st  = ST_DUMMY;                                                 // R2
              n.cnt = DUMMY_CLKS_QOUT;
            end else begin
              n.st  = ST_MODE;                                                  // R5
              n.cnt = (q.lanes == LANES_DUAL) ? MODE_CLKS_DUAL : MODE_CLKS_QUAD;
            end
          end
        end
        ST_MODE: begin
          if (q.cnt == 5'h01) begin
            n.cont     = (shifted[MODE_SEL_HI:MODE_SEL_LO] == MODE_SEL_CONT);  // R5 R6 R7
            n.cont_cmd = q.cmd;
            n.dclk     = 3'h0;
            if (q.cmd == OPC_DUAL_IO_READ) begin
              n.st = ST_DATA;
            end else if (!i_four_wire_command_mode) begin
              n.st  = ST_DUMMY;                                                 // R10
              n.cnt = DUMMY_CLKS_QIO_SPI;
            end else if (qpi_dummy == 5'h00) begin
              n.st = ST_DATA;                                                   // R18
            end else begin
              n.st  = ST_DUMMY;                                                 // R17
              n.cnt = qpi_dummy;
            end
          end
        end
        ST_DUMMY: begin
          n.sh = '0;                                                            // R2
          if (q.cnt == 5'h01) begin
            n.st   = ST_DATA;
            n.dclk = 3'h0;
          end
        end
        ST_SET_WRAP: begin
          if (q.cnt == 5'h01) begin
            n.wrap = shifted[WRAP_FIELD_HI:WRAP_FIELD_LO];                      // R13 R14 R15
            n.st   = ST_IGNORE;
          end
        end
        ST_DATA: begin
          n.sh  = q.sh;
          n.cnt = q.cnt;
        end
        ST_IGNORE: begin
          n.sh  = q.sh;
          n.cnt = q.cnt;
        end
        default: begin
          n.st = ST_IGNORE;
        end
      endcase
    end else if (fall && q.st == ST_DATA) begin
      // Shift the next group of bits out, reloading per byte
      if (q.dclk == 3'h0) begin
        n.addr = addr_next;                                                     // R22
        n.dclk = 3'((BYTE_BITS / data_lanes) - 1);
      end else begin
        load_byte = q.dbyte;
        n.dclk    = q.dclk - 3'h1;
      end
      if (data_lanes == LANES_DUAL) begin
        n.io_out  = {2'h0, load_byte[7:6]};                                     // R4 R23
        n.io_oe_n = OE_DUAL;
        n.dbyte   = {load_byte[5:0], 2'h0};
      end else begin
        n.io_out  = load_byte[7:4];                                             // R1 R10 R23
        n.io_oe_n = OE_QUAD;
        n.dbyte   = {load_byte[3:0], 4'h0};
      end
    end

    // Data phase flag registered so the output comes from a flop
    n.data_ph = (n.st == ST_DATA) && !n.cs_n_s[1];
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      q.cs_n_s    <= 2'h3;
      q.sclk_s    <= 2'h0;
      q.io_s      <= '0;
      q.sclk_d    <= 1'b0;
      q.st        <= ST_OPCODE;
      q.cmd       <= 8'h00;
      q.lanes     <= LANES_SINGLE;
      q.cnt       <= OPC_CLKS_SERIAL;
      q.sh        <= '0;
      q.addr      <= '0;
      q.dbyte     <= 8'h00;
      q.dclk      <= 3'h0;
      q.cont      <= 1'b0;
      q.cont_cmd  <= 8'h00;
      q.wrap      <= WRAP_RESET;                                                // R16
      q.dummy_sel <= DUMMY_SEL_RESET;                                           // R17
      q.io_out    <= 4'h0;
      q.io_oe_n   <= OE_RELEASED;
      q.data_ph   <= 1'b0;
    end else begin
      q <= n;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_io_out                 = q.io_out;
  assign o_io_oe_n                = q.io_oe_n;
  assign o_mem_addr               = q.addr;
  assign o_wrap_setting_bits      = q.wrap;
  assign o_dummy_sel              = q.dummy_sel;
  assign o_continuous_read_active = q.cont;
  assign o_data_phase             = q.data_ph;

endmodule : multi_io_fast_read_wrap

`default_nettype wire

//--- shared/fast_read_pkg.sv
// Constants, types and state layout of the multi-line fast read sequencer
`default_nettype none

package fast_read_pkg;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OPC_QUAD_OUT_READ = 8'h6b;
  localparam logic [7:0] OPC_DUAL_IO_READ  = 8'hbb;
  localparam logic [7:0] OPC_QUAD_IO_READ  = 8'heb;
  localparam logic [7:0] OPC_SET_WRAP      = 8'h77;

  // ==========================================================================
  // Lane widths, in bits per serial clock
  localparam logic [2:0] LANES_SINGLE = 3'h1;
  localparam logic [2:0] LANES_DUAL   = 3'h2;
  localparam logic [2:0] LANES_QUAD   = 3'h4;

  // ==========================================================================
  // Phase lengths, in serial clocks
  localparam logic [4:0] OPC_CLKS_SERIAL    = 5'h08;
  localparam logic [4:0] OPC_CLKS_QUAD      = 5'h02;
  localparam logic [4:0] ADDR_CLKS_SINGLE   = 5'h18;
  localparam logic [4:0] ADDR_CLKS_DUAL     = 5'h0c;
  localparam logic [4:0] ADDR_CLKS_QUAD     = 5'h06;
  localparam logic [4:0] MODE_CLKS_DUAL     = 5'h04;
  localparam logic [4:0] MODE_CLKS_QUAD     = 5'h02;
  localparam logic [4:0] DUMMY_CLKS_QOUT    = 5'h08;
  localparam logic [4:0] DUMMY_CLKS_QIO_SPI = 5'h04;
  localparam logic [4:0] DUMMY_STEP_QPI     = 5'h02;
  localparam logic [4:0] SET_WRAP_CLKS      = 5'h08;

  // ==========================================================================
  // Mode byte, wrap byte and read parameter fields
  localparam int         MODE_SEL_HI      = 5;
  localparam int         MODE_SEL_LO      = 4;
  localparam logic [1:0] MODE_SEL_CONT    = 2'h2;
  localparam int         WRAP_FIELD_HI    = 6;
  localparam int         WRAP_FIELD_LO    = 4;
  localparam int         WRAP_DIS_IDX     = 0;
  localparam logic [2:0] WRAP_RESET       = 3'h1;
  localparam logic [1:0] DUMMY_SEL_RESET  = 2'h0;
  localparam logic [7:0] WRAP_MIN_BYTES   = 8'h08;
  localparam int         ADDR_BITS        = 24;

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_MODE,
    ST_DUMMY,
    ST_DATA,
    ST_SET_WRAP,
    ST_IGNORE
  } seq_state_t;

  // Read parameters as loaded by the read-parameter command
  typedef struct packed {
    logic [1:0] dummy_sel;
    logic [1:0] wrap_len;
  } read_param_t;

  typedef struct packed {
    logic [1:0]           cs_n_s;
    logic [1:0]           sclk_s;
    logic [1:0][3:0]      io_s;
    logic                 sclk_d;
    seq_state_t           st;
    logic [7:0]           cmd;
    logic [2:0]           lanes;
    logic [4:0]           cnt;
    logic [ADDR_BITS-1:0] sh;
    logic [ADDR_BITS-1:0] addr;
    logic [7:0]           dbyte;
    logic [2:0]           dclk;
    logic                 cont;
    logic [7:0]           cont_cmd;
    logic [2:0]           wrap;
    logic [1:0]           dummy_sel;
    logic [3:0]           io_out;
    logic [3:0]           io_oe_n;
    logic                 data_ph;
  } seq_regs_t;

endpackage : fast_read_pkg

`default_nettype wire

//--- dv/fast_read_monitor.sv
// Port assertions for the multi-line fast read sequencer
`default_nettype none
module fast_read_monitor
  import fast_read_pkg::*;
(
  input wire logic                 i_mclk,
  input wire logic                 i_sys_rst,
  input wire logic                 i_cs_n,
  input wire logic                 i_four_wire_command_mode,
  input wire read_param_t          i_read_param,
  input wire logic                 i_read_param_load,
  input wire logic [3:0]           o_io_oe_n,
  input wire logic [ADDR_BITS-1:0] o_mem_addr,
  input wire logic [2:0]           o_wrap_setting_bits,
  input wire logic [1:0]           o_dummy_sel,
  input wire logic                 o_continuous_read_active,
  input wire logic                 o_data_phase
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  logic [23:0] wm;
  assign wm = {16'h0, (8'h08 << o_wrap_setting_bits[2:1]) - 8'h01};
  sequence cs_idle;
    i_cs_n [*6];
  endsequence
  sequence byte_step;
    $past(o_data_phase) && o_data_phase && $changed(o_mem_addr);
  endsequence
  a_reset_wrap_dummy: assert property ($fell(i_sys_rst) |-> o_wrap_setting_bits == 3'h1 && o_dummy_sel == 2'h0)
    else $error("wrap or dummy setting not at reset value");
  a_reset_lines_free: assert property ($fell(i_sys_rst) |-> o_io_oe_n == 4'hf && !o_continuous_read_active)
    else $error("lines driven or continuous mode set after reset");
  a_param_load_takes: assert property (cs_idle ##0 i_read_param_load |=> o_dummy_sel == $past(i_read_param.dummy_sel)
    && o_wrap_setting_bits[2:1] == $past(i_read_param.wrap_len) && o_wrap_setting_bits[0] == $past(o_wrap_setting_bits[0]))
    else $error("read parameter load not taken");
  a_idle_lines_free: assert property (cs_idle |-> o_io_oe_n == 4'hf && !o_data_phase)
    else $error("lines driven while deselected");
  a_lane_pattern: assert property (o_io_oe_n inside {4'hf, 4'hc, 4'h0})
    else $error("illegal lane enable pattern");
  a_drive_in_data: assert property (o_io_oe_n != 4'hf |-> o_data_phase || $past(o_data_phase))
    else $error("lines driven outside data phase");
  a_cont_kept: assert property (o_continuous_read_active && i_cs_n |=> o_continuous_read_active)
    else $error("continuous mode lost between frames");
  a_addr_linear: assert property (byte_step ##0 (o_wrap_setting_bits[0] || i_four_wire_command_mode)
    |-> o_mem_addr == $past(o_mem_addr) + 24'h1)
    else $error("address did not advance by one");
  a_wrap_section: assert property (byte_step ##0 (!o_wrap_setting_bits[0] && !i_four_wire_command_mode)
    |-> o_mem_addr == (($past(o_mem_addr) & ~wm) | (($past(o_mem_addr) + 24'h1) & wm)))
    else $error("address left the wrap section");
endmodule : fast_read_monitor
bind multi_io_fast_read_wrap fast_read_monitor u_fast_read_monitor (.i_mclk, .i_sys_rst, .i_cs_n,
  .i_four_wire_command_mode, .i_read_param, .i_read_param_load, .o_io_oe_n, .o_mem_addr,
  .o_wrap_setting_bits, .o_dummy_sel, .o_continuous_read_active, .o_data_phase);
`default_nettype wire

//--- dv/host_model.sv
// Host flash controller model driving chip select, clock and IO lines
`default_nettype none
module host_model (
  input  wire logic [3:0] i_dout,
  input  wire logic [3:0] i_oe_n,
  output logic            o_cs_n,
  output logic            o_sclk,
  output logic [3:0]      o_io
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       en;
  logic [3:0] hv;
  // Released lines show the last host value while the host drives, else its inverse
  assign o_io = (~i_oe_n & i_dout) | (i_oe_n & (en ? hv : ~hv));
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    en = 1'b0;
    hv = 4'h0;
  end
  task automatic start;
    #3;
    o_cs_n = 1'b0;
    #80;
  endtask : start
  task automatic stop;
    #80;
    o_cs_n = 1'b1;
    en = 1'b0;
    #250;
  endtask : stop
  // n clocks on w lanes, highest group first
  task automatic shift(input logic [31:0] v, input int n, input int w);
    en = 1'b1;
    for (int k = n - 1; k >= 0; k--) begin
      hv = 4'((v >> (k * w)) & ((32'h1 << w) - 1));
      #80 o_sclk = 1'b1;
      // Release after hold time, well before the first data fall
      #40 if (k == 0) en = 1'b0;
      #40 o_sclk = 1'b0;
    end
  endtask : shift
  task automatic get(output logic [7:0] b, input int w);
    b = 8'h0;
    for (int k = 0; k < 8 / w; k++) begin
      #80 b = (b << w) | 8'(o_io & 4'((32'h1 << w) - 1));
      o_sclk = 1'b1;
      #80 o_sclk = 1'b0;
    end
  endtask : get
endmodule : host_model
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the multi-line fast read sequencer
`default_nettype none
module testbench
  import fast_read_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_mclk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        qe = 1'b1;
  logic        fw = 1'b0;
  read_param_t rp = '0;
  logic        ld = 1'b0;
  logic        cs_n, sclk, cont;
  logic [3:0]  io, dout, oe_n;
  logic [23:0] addr;
  logic [2:0]  wbits;
  logic [1:0]  dsel;
  logic [7:0]  mdat;
  logic [7:0]  ops [2] = '{8'h6b, 8'heb};
  int          mismatches = 0;
  int          num_checks = 0;
  int          cycles = 0;
  assign mdat = addr[7:0] ^ addr[15:8] ^ 8'h5a;
  always #5 i_mclk = ~i_mclk;
  multi_io_fast_read_wrap u_multi_io_fast_read_wrap (.i_mclk, .i_sys_rst, .i_cs_n(cs_n), .i_sclk(sclk),
    .i_io_in(io), .i_quad_enable_bit(qe), .i_four_wire_command_mode(fw), .i_read_param(rp),
    .i_read_param_load(ld), .i_mem_data(mdat), .o_io_out(dout), .o_io_oe_n(oe_n), .o_mem_addr(addr),
    .o_wrap_setting_bits(wbits), .o_dummy_sel(dsel), .o_continuous_read_active(cont), .o_data_phase());
  host_model host (.i_dout(dout), .i_oe_n(oe_n), .o_cs_n(cs_n), .o_sclk(sclk), .o_io(io));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      give_verdict;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rdchk(input logic [23:0] a, input int n, input int w, input logic [23:0] wm);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      host.get(b, w);
      chk("read byte", 32'(b), 32'(a[7:0] ^ a[15:8] ^ 8'h5a));
      a = (a & ~wm) | ((a + 24'h1) & wm);
    end
  endtask : rdchk
  task automatic qio(input logic op, input logic [23:0] a, input logic [7:0] m, input int n, input int dn,
                     input logic [23:0] wm);
    host.start;
    if (op) host.shift(32'heb, fw ? 2 : 8, fw ? 4 : 1);
    host.shift(32'(a), 6, 4);
    host.shift(32'(m), 2, 4);
    if (dn > 0) host.shift(32'h0, dn, 4);
    rdchk(a, n, 4, wm);
    host.stop;
  endtask : qio
  task automatic setwrap(input logic [7:0] w);
    host.start;
    host.shift(32'h77, 8, 1);
    host.shift(32'h0, 6, 4);
    host.shift(32'(w), 2, 4);
    host.stop;
  endtask : setwrap
  task automatic load(input logic [1:0] s, input logic [1:0] l);
    @(posedge i_mclk);
    rp <= '{dummy_sel: s, wrap_len: l};
    ld <= 1'b1;
    @(posedge i_mclk);
    ld <= 1'b0;
    @(posedge i_mclk);
    #1;
  endtask : load
  initial begin
    repeat (16) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_mclk);
    #1;
    chk("wrap bits", 32'(wbits), 32'h1);
    chk("dummy sel", 32'(dsel), 32'h0);
    $display("test reset done");
    host.start;
    host.shift(32'h6b, 8, 1);
    host.shift(32'h00f0ff, 24, 1);
    host.shift(32'h5a5a5a5a, 8, 4);
    rdchk(24'h00f0ff, 3, 4, 24'hffffff);
    host.stop;
    host.start;
    host.shift(32'hbb, 8, 1);
    host.shift(32'h123456, 12, 2);
    host.shift(32'h20, 4, 2);
    rdchk(24'h123456, 2, 2, 24'hffffff);
    chk("dual lanes", 32'(oe_n), 32'hc);
    host.stop;
    chk("cont on", 32'(cont), 32'h1);
    host.start;
    host.shift(32'h555555, 12, 2);
    host.shift(32'h55, 4, 2);
    rdchk(24'h555555, 2, 2, 24'hffffff);
    host.stop;
    chk("cont off", 32'(cont), 32'h0);
    $display("test serial reads done");
    @(posedge i_mclk);
    qe <= 1'b0;
    foreach (ops[i]) begin
      host.start;
      host.shift(32'(ops[i]), 8, 1);
      host.shift(32'h0, 36, 1);
      chk("refused", 32'(oe_n), 32'hf);
      host.stop;
    end
    @(posedge i_mclk);
    qe <= 1'b1;
    $display("test refusal done");
    for (int l = 0; l < 4; l++) begin
      setwrap({1'b1, 2'(l), 1'b0, 4'ha});
      chk("wrap bits", 32'(wbits), 32'(l * 2));
      qio(1'b1, 24'h300 + 24'((8 << l) - 1), 8'h00, 2, 4, 24'((8 << l) - 1));
    end
    qio(1'b1, 24'h00013f, 8'ha0, 2, 4, 24'h3f);
    chk("cont on", 32'(cont), 32'h1);
    qio(1'b0, 24'h111111, 8'h11, 2, 4, 24'h3f);
    chk("cont off", 32'(cont), 32'h0);
    $display("test wrap and continuous done");
    @(posedge i_mclk);
    fw <= 1'b1;
    host.start;
    host.shift(32'h6b, 2, 4);
    host.shift(32'h0, 36, 4);
    chk("refused", 32'(oe_n), 32'hf);
    host.stop;
    for (int s = 0; s < 4; s++) begin
      load(2'(s), 2'h2);
      chk("dummy sel", 32'(dsel), 32'(s));
      chk("wrap bits", 32'(wbits), 32'h4);
      qio(1'b1, 24'h0000ff, 8'h00, 2, 2 * s, 24'hffffff);
    end
    qio(1'b1, 24'h000422, 8'ha0, 1, 6, 24'hffffff);
    chk("cont on", 32'(cont), 32'h1);
    qio(1'b0, 24'h000433, 8'hff, 1, 6, 24'hffffff);
    chk("cont off", 32'(cont), 32'h0);
    $display("test four-wire done");
    @(posedge i_mclk);
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    fw <= 1'b0;
    repeat (4) @(posedge i_mclk);
    #1;
    chk("wrap bits", 32'(wbits), 32'h1);
    chk("dummy sel", 32'(dsel), 32'h0);
    $display("test second reset done");
    give_verdict;
  end
endmodule : testbench
`default_nettype wire
